// ==== inc/fnd_defines.vh ====
/*
 * Constants for the negative multiply-subtract, logic and lock-wait
 * decoder: opcodes, sub-opcodes, formats, cause bit positions, masks.
 * Assumes inclusion by the decoder module only; holds definitions only.
 */
`ifndef FND_DEFINES_VH
`define FND_DEFINES_VH

// =====================================================================
// Instruction encodings
// =====================================================================
`define FND_OP_SPECIAL    6'h00      // Register-class major opcode
`define FND_OP_FPX        6'h13      // fp_extended_opcode major opcode
`define FND_OP_IMM_OR     6'h0d      // immediate_disjunction opcode
`define FND_SUB_NEGMUL    3'h7       // Sub-opcode in bits 5..3
`define FND_FN_SHIFT      6'h00      // shift_left_logical function
`define FND_FN_NOR        6'h27      // NOR function code
`define FND_FN_OR         6'h25      // OR function code
`define FND_PAUSE_SHAMT   5'h05      // Shift amount marking lock-wait
`define FND_WORD_ZERO     32'h00000000 // no_operation word
`define FND_FIELD15_ZERO  15'h0000   // Zero register fields of lock-wait
`define FND_SHAMT_ZERO    5'h00      // Zero shift-amount field
`define FND_IMM_PAD       16'h0000   // Zero extension of immediate

// =====================================================================
// Operand formats (bits 2..0)
// =====================================================================
`define FND_FMT_S         3'h0       // Single
`define FND_FMT_D         3'h1       // Double
`define FND_FMT_PS        3'h6       // Paired single

// =====================================================================
// Cause bits: E V Z O U I
// =====================================================================
`define FND_CAUSE_E       5          // Unimplemented operation
`define FND_CAUSE_W       6          // Cause width
`define FND_FLAG_W        5          // Sticky flag width
`define FND_CAUSE_ZERO    6'h00      // No cause raised
`define FND_FLAGS_RST     5'h00      // Flags after reset

// =====================================================================
// Arithmetic requests and lane masks
// =====================================================================
`define FND_FPU_MUL       1'b0       // Multiply request
`define FND_FPU_SUB       1'b1       // Subtract request
`define FND_SIGN_S        32'h80000000 // Sign of a single lane
`define FND_SIGN_D        64'h8000000000000000 // Sign of a double
`define FND_LANE_PAD      32'h00000000 // Upper pad of a single lane

`endif

// ==== logic/fnd_decode.v ====
/*
 * Decode and execute for negative multiply-subtract (scalar, paired),
 * no_operation, NOR, OR, immediate_disjunction and the lock-wait hint.
 * Assumes a same-clock pipeline, combinational register file reads and
 * an external floating multiply/subtract unit with a req/ack handshake.
 */
// Operation
// - Decode negative multiply-subtract opcode and fields
// - Multiply, round, subtract addend, round, negate
// - Match separate multiply, subtract, negate results
// - Paired form runs both halves, ORs causes
// - OR causes into sticky flags when untrapped
// - Paired defined only on 64-bit unit, mode one
// - Raise unusable, reserved and floating exceptions
// - Absent under release six, scalar and paired otherwise
// - All-zero word does nothing, raises nothing
// - NOR of two sources to destination
// - OR of two sources to destination
// - Zero-extended immediate OR into second field
// - Lock-wait decoded from shift with amount five
// - Single-thread stall until flag clear or event
// - Multi-thread deschedule until flag reads zero
// - Foreign store to lock clears reservation flag
// - Unimplemented lock-wait acts as no_operation
// - Release six lock-wait in slot is reserved
// - Linked load sets the reservation flag
`timescale 1ns/10ps
`include "fnd_defines.vh"

module fnd_decode (
  input  wire        clk_i,                // Core clock, 10 MHz
  input  wire        reset_n_i,            // Asynchronous reset, active low
  input  wire        instr_valid_i,        // Instruction word offered
  input  wire [31:0] instr_i,              // Instruction word
  input  wire        in_delay_slot_i,      // Word sits in a delay/forbidden slot
  output wire        ready_o,              // Instruction taken this cycle if valid
  output reg         done_o,               // Instruction retired, one cycle
  output reg         except_ri_o,          // Reserved instruction, one cycle
  output reg         except_cpu_o,         // Coprocessor unusable, one cycle
  output reg         except_fpe_o,         // Floating exception taken, one cycle
  output reg         unclaimed_o,          // Word not of this group, one cycle
  input  wire        release6_i,           // Core conforms to release six
  input  wire        fpu_present_i,        // Floating unit present
  input  wire        fpu64_i,              // Floating unit is 64-bit
  input  wire        fp_reg_width_mode_i,  // Register width mode bit
  input  wire        cop1_usable_i,        // Floating coprocessor enabled
  input  wire        pause_impl_i,         // Lock-wait stall implemented
  input  wire        multithread_i,        // Core is multi-threaded
  input  wire        external_event_i,     // Interrupt or other wake event
  input  wire        linked_load_i,        // A linked_load executed
  input  wire        lock_store_i,         // Other stream stored to lock
  output reg         link_reservation_flag_o, // Reservation flag state
  output wire        issue_stall_o,        // Single-thread issue stalled
  output wire        thread_deschedule_o,  // Thread descheduled
  output wire [4:0]  src_gpr_a_o,          // First source register number
  output wire [4:0]  src_gpr_b_o,          // Second source register number
  input  wire [31:0] gpr_a_data_i,         // First source value
  input  wire [31:0] gpr_b_data_i,         // Second source value
  output reg         gpr_we_o,             // general_register write strobe
  output reg  [4:0]  gpr_waddr_o,          // Destination register number
  output reg  [31:0] gpr_wdata_o,          // Destination value
  output wire [4:0]  addend_reg_o,         // Addend float_register number
  output wire [4:0]  multiplier_reg_o,     // Multiplier float_register number
  output wire [4:0]  multiplicand_reg_o,   // Multiplicand float_register number
  input  wire [63:0] addend_data_i,        // Addend value
  input  wire [63:0] multiplier_data_i,    // Multiplier value
  input  wire [63:0] multiplicand_data_i,  // Multiplicand value
  output reg         fpr_we_o,             // float_register write strobe
  output reg  [4:0]  fpr_waddr_o,          // dest_fp_reg number
  output reg  [63:0] fpr_wdata_o,          // Result value
  output wire        fpu_req_o,            // Arithmetic request
  output wire        fpu_op_o,             // 0 multiply, 1 subtract
  output reg         fpu_double_o,         // Double precision request
  output reg  [63:0] fpu_a_o,              // First operand
  output reg  [63:0] fpu_b_o,              // Second operand
  input  wire        fpu_ack_i,            // Result and cause valid
  input  wire [63:0] fpu_result_i,         // Rounded result
  input  wire [5:0]  fpu_cause_i,          // Cause bits E V Z O U I
  input  wire [4:0]  fp_enables_i,         // Trap enables V Z O U I
  input  wire        flags_wr_i,           // Software writes sticky flags
  input  wire [4:0]  flags_wdata_i,        // Flag value written
  output reg  [4:0]  fp_flags_o,           // Sticky flags of fp_control_status
  output reg  [5:0]  fp_cause_o            // Cause of the last operation
);

  // ===================================================================
  // Helper functions
  // ===================================================================
  // Selects a 32-bit lane in paired mode, the whole word otherwise
  function [63:0] fnd_lane;
    input [63:0] v;
    input        ps;
    input        upper;
    begin
      if (ps) begin
        fnd_lane = {`FND_LANE_PAD, (upper ? v[63:32] : v[31:0])};
      end else begin
        fnd_lane = v;
      end
    end
  endfunction

  // True when a cause must trap instead of completing
  function fnd_traps;
    input [5:0] cause;
    input [4:0] en;
    begin
      fnd_traps = cause[`FND_CAUSE_E] | (|(cause[4:0] & en));
    end
  endfunction

  // ===================================================================
  // Decode
  // ===================================================================
  wire [5:0] opcode   = instr_i[31:26];     // Major opcode
  wire [5:0] funct    = instr_i[5:0];       // Function code
  wire [4:0] shamt    = instr_i[10:6];      // Shift amount field
  wire [2:0] fmt      = instr_i[2:0];       // operand_format
  wire       fmt_ps   = (fmt == `FND_FMT_PS); // Paired single
  wire       fmt_ok   = (fmt == `FND_FMT_S) | (fmt == `FND_FMT_D) | fmt_ps;
  wire       dec_fmuls = (opcode == `FND_OP_FPX) &
                         (instr_i[5:3] == `FND_SUB_NEGMUL);
  wire       dec_zero  = (instr_i == `FND_WORD_ZERO);
  wire       dec_pause = (opcode == `FND_OP_SPECIAL) &
                         (instr_i[25:11] == `FND_FIELD15_ZERO) &
                         (shamt == `FND_PAUSE_SHAMT) &
                         (funct == `FND_FN_SHIFT);
  wire       special_r = (opcode == `FND_OP_SPECIAL) & (shamt == `FND_SHAMT_ZERO);
  wire       dec_nor   = special_r & (funct == `FND_FN_NOR);
  wire       dec_or    = special_r & (funct == `FND_FN_OR);
  wire       dec_immor = (opcode == `FND_OP_IMM_OR);

  assign src_gpr_a_o        = instr_i[25:21];
  assign src_gpr_b_o        = instr_i[20:16];
  assign addend_reg_o       = instr_i[25:21];
  assign multiplier_reg_o   = instr_i[20:16];
  assign multiplicand_reg_o = instr_i[15:11];

  // ===================================================================
  // State
  // ===================================================================
  reg  [1:0]  state;        // Sequencer state
  localparam ST_IDLE = 2'h0, ST_MUL = 2'h1, ST_SUB = 2'h2, ST_PAUSE = 2'h3; // State codes
  reg         ps_q;         // Paired operation in flight
  reg         half;         // 0 lower lane, 1 upper lane
  reg  [4:0]  dest_q;       // dest_fp_reg captured
  reg  [63:0] addend_q;     // Addend captured
  reg  [63:0] mult_q;       // Multiplier captured
  reg  [63:0] mcand_q;      // Multiplicand captured
  reg  [63:0] result_q;     // Result being assembled
  reg  [5:0]  cause_acc;    // Causes of this instruction so far

  wire take     = instr_valid_i & (state == ST_IDLE); // Word accepted
  wire fpu_done = fpu_ack_i & ((state == ST_MUL) | (state == ST_SUB));
  wire [5:0] cause_all = cause_acc | fpu_cause_i;
  wire trap     = fpu_done & fnd_traps(fpu_cause_i, fp_enables_i);
  wire last     = (state == ST_SUB) & fpu_ack_i & ~trap & (~ps_q | half);
  wire pause_end = ~link_reservation_flag_o |
                   (~multithread_i & external_event_i);

  assign ready_o             = (state == ST_IDLE);
  assign fpu_req_o           = (state == ST_MUL) | (state == ST_SUB);
  assign fpu_op_o            = (state == ST_SUB) ? `FND_FPU_SUB : `FND_FPU_MUL;
  assign issue_stall_o       = (state == ST_PAUSE) & ~multithread_i;
  assign thread_deschedule_o = (state == ST_PAUSE) & multithread_i;

  // Negated difference of the current lane, sign bit inverted
  wire [63:0] neg_lane = fpu_double_o ? (fpu_result_i ^ `FND_SIGN_D) :
                         {fpu_result_i[63:32], fpu_result_i[31:0] ^ `FND_SIGN_S};

  // ===================================================================
  // Reservation flag: a linked load sets it, a foreign store clears it
  // ===================================================================
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_reservation_flag_o <= 1'b0;
    end else if (linked_load_i) begin
      link_reservation_flag_o <= 1'b1;
    end else if (lock_store_i) begin
      link_reservation_flag_o <= 1'b0;
    end
  end

  // ===================================================================
  // Sticky flags: completed causes are ORed in, set beats a write
  // ===================================================================
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fp_flags_o <= `FND_FLAGS_RST;
    end else begin
      fp_flags_o <= (flags_wr_i ? flags_wdata_i : fp_flags_o) |
                    (last ? cause_all[4:0] : `FND_FLAGS_RST);
    end
  end

  // ===================================================================
  // Sequencer
  // ===================================================================
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state        <= ST_IDLE;
      ps_q         <= 1'b0;
      half         <= 1'b0;
      dest_q       <= 5'h00;
      addend_q     <= 64'h0000000000000000;
      mult_q       <= 64'h0000000000000000;
      mcand_q      <= 64'h0000000000000000;
      result_q     <= 64'h0000000000000000;
      cause_acc    <= `FND_CAUSE_ZERO;
      fpu_double_o <= 1'b0;
      fpu_a_o      <= 64'h0000000000000000;
      fpu_b_o      <= 64'h0000000000000000;
      done_o       <= 1'b0;
      except_ri_o  <= 1'b0;
      except_cpu_o <= 1'b0;
      except_fpe_o <= 1'b0;
      unclaimed_o  <= 1'b0;
      gpr_we_o     <= 1'b0;
      gpr_waddr_o  <= 5'h00;
      gpr_wdata_o  <= 32'h00000000;
      fpr_we_o     <= 1'b0;
      fpr_waddr_o  <= 5'h00;
      fpr_wdata_o  <= 64'h0000000000000000;
      fp_cause_o   <= `FND_CAUSE_ZERO;
    end else begin
      // Pulses default low each cycle
      done_o       <= 1'b0;
      except_ri_o  <= 1'b0;
      except_cpu_o <= 1'b0;
      except_fpe_o <= 1'b0;
      unclaimed_o  <= 1'b0;
      gpr_we_o     <= 1'b0;
      fpr_we_o     <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            if (dec_fmuls) begin
              if (release6_i | ~fpu_present_i | ~fmt_ok) begin
                except_ri_o <= 1'b1;
              end else if (~cop1_usable_i) begin
                except_cpu_o <= 1'b1;
              end else if (fmt_ps & ~(fpu64_i & fp_reg_width_mode_i)) begin
                except_ri_o <= 1'b1;
              end else begin
                // Capture operands, issue the lower or only multiply
                state        <= ST_MUL;
                ps_q         <= fmt_ps;
                half         <= 1'b0;
                dest_q       <= instr_i[10:6];
                addend_q     <= addend_data_i;
                mult_q       <= multiplier_data_i;
                mcand_q      <= multiplicand_data_i;
                cause_acc    <= `FND_CAUSE_ZERO;
                fpu_double_o <= (fmt == `FND_FMT_D);
                fpu_a_o      <= fnd_lane(multiplicand_data_i, fmt_ps, 1'b0);
                fpu_b_o      <= fnd_lane(multiplier_data_i, fmt_ps, 1'b0);
              end
            end else if (dec_pause) begin
              if (release6_i & in_delay_slot_i) begin
                except_ri_o <= 1'b1;
              end else if (pause_impl_i & link_reservation_flag_o) begin
                state <= ST_PAUSE;
              end else begin
                done_o <= 1'b1;
              end
            end else if (dec_zero) begin
              done_o <= 1'b1;
            end else if (dec_nor | dec_or) begin
              gpr_we_o    <= 1'b1;
              gpr_waddr_o <= instr_i[15:11];
              gpr_wdata_o <= dec_nor ? ~(gpr_a_data_i | gpr_b_data_i) :
                                       (gpr_a_data_i | gpr_b_data_i);
              done_o      <= 1'b1;
            end else if (dec_immor) begin
              gpr_we_o    <= 1'b1;
              gpr_waddr_o <= instr_i[20:16];
              gpr_wdata_o <= gpr_a_data_i | {`FND_IMM_PAD, instr_i[15:0]};
              done_o      <= 1'b1;
            end else begin
              unclaimed_o <= 1'b1;
            end
          end
        end
        ST_MUL: begin
          if (fpu_ack_i) begin
            cause_acc <= cause_all;
            if (trap) begin
              // Multiply traps on its own, as a separate one would
              except_fpe_o <= 1'b1;
              fp_cause_o   <= cause_all;
              state        <= ST_IDLE;
            end else begin
              fpu_a_o <= fpu_result_i;
              fpu_b_o <= fnd_lane(addend_q, ps_q, half);
              state   <= ST_SUB;
            end
          end
        end
        ST_SUB: begin
          if (fpu_ack_i) begin
            cause_acc <= cause_all;
            if (trap) begin
              except_fpe_o <= 1'b1;
              fp_cause_o   <= cause_all;
              state        <= ST_IDLE;
            end else if (ps_q & ~half) begin
              // Lower lane stored, run the upper lane
              result_q[31:0] <= neg_lane[31:0];
              half    <= 1'b1;
              fpu_a_o <= fnd_lane(mcand_q, 1'b1, 1'b1);
              fpu_b_o <= fnd_lane(mult_q, 1'b1, 1'b1);
              state   <= ST_MUL;
            end else begin
              fpr_we_o    <= 1'b1;
              fpr_waddr_o <= dest_q;
              fpr_wdata_o <= ps_q ? {neg_lane[31:0], result_q[31:0]} : neg_lane;
              fp_cause_o  <= cause_all;
              done_o      <= 1'b1;
              state       <= ST_IDLE;
            end
          end
        end
        ST_PAUSE: begin
          if (pause_end) begin
            done_o <= 1'b1;
            state  <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== verif/fnd_decode_sva.sv ====
/* Checker for the fnd_decode block: timing relations at its ports.
   Assumes it is bound into every fnd_decode instance, one clock domain. */
`timescale 1ns/10ps
// ==================================================================
// Checker
// ==================================================================
module fnd_decode_sva (
  input logic        clk_i, reset_n_i, instr_valid_i, in_delay_slot_i, release6_i,
  input logic [31:0] instr_i, gpr_a_data_i, gpr_b_data_i, gpr_wdata_o,
  input logic        ready_o, done_o, except_ri_o, gpr_we_o, fpr_we_o, linked_load_i,
  input logic        lock_store_i, link_reservation_flag_o, issue_stall_o,
  input logic        thread_deschedule_o,
  input logic [4:0]  gpr_waddr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire        take  = instr_valid_i && ready_o;  // Word accepted this cycle
  wire [5:0]  op    = instr_i[31:26];            // Major opcode
  wire [15:0] imm   = instr_i[15:0];             // Immediate field
  wire [4:0]  dst_f = instr_i[20:16];            // Second register field
  wire        rtype = take && op == 6'h00 && instr_i[10:6] == 5'h00; // Register-class word
  a_nor_value: assert property (rtype && instr_i[5:0] == 6'h27 |=> gpr_we_o &&
    gpr_wdata_o == ~($past(gpr_a_data_i) | $past(gpr_b_data_i))) else $error("nor result wrong");
  a_or_value: assert property (rtype && instr_i[5:0] == 6'h25 |=> gpr_we_o &&
    gpr_wdata_o == ($past(gpr_a_data_i) | $past(gpr_b_data_i))) else $error("or result wrong");
  a_immor_zext: assert property (take && op == 6'h0d |=> gpr_waddr_o == $past(dst_f) &&
    gpr_wdata_o == ($past(gpr_a_data_i) | {16'h0000, $past(imm)})) else $error("ori wrong");
  a_zero_quiet: assert property (take && instr_i == 32'h00000000 |=> done_o &&
    !gpr_we_o && !fpr_we_o && !except_ri_o) else $error("zero word had an effect");
  a_pause_slot: assert property (take && instr_i == 32'h00000140 && release6_i
    && in_delay_slot_i |=> except_ri_o && !done_o) else $error("pause in slot not refused");
  a_negmul_gone: assert property (take && op == 6'h13 && instr_i[5:3] == 3'h7
    && release6_i |=> except_ri_o) else $error("mul-sub accepted under release six");
  a_link_set: assert property (linked_load_i |=> link_reservation_flag_o)
    else $error("flag not set by linked load");
  a_link_clear: assert property (lock_store_i && !linked_load_i |=>
    !link_reservation_flag_o) else $error("flag not cleared by store");
  a_stall_wake: assert property (issue_stall_o && !link_reservation_flag_o |=>
    done_o && !issue_stall_o) else $error("stall not released");
  a_desched_hold: assert property (thread_deschedule_o && link_reservation_flag_o
    |=> !done_o) else $error("thread resumed with flag set");
  c_fp_write: cover property (fpr_we_o);
  c_stall: cover property (issue_stall_o);
  c_desched: cover property (thread_deschedule_o);
endmodule

bind fnd_decode fnd_decode_sva u_sva (.*);

// ==== verif/tb.sv ====
/* Self-checking bench for fnd_decode; the bench also plays the
   register files and the floating multiply/subtract unit. */
`timescale 1ns/10ps
module tb;
  // ================================================================
  // Stimulus and observed signals
  // ================================================================
  logic clk_i = 0, reset_n_i = 0, instr_valid_i = 0, in_delay_slot_i = 0, release6_i = 0;
  logic fpu_present_i = 1, fpu64_i = 1, fp_reg_width_mode_i = 1, cop1_usable_i = 1;
  logic pause_impl_i = 0, multithread_i = 0, external_event_i = 0, linked_load_i = 0;
  logic lock_store_i = 0, fpu_ack_i = 0, flags_wr_i = 0;
  logic [31:0] instr_i = 0, gpr_a_data_i = 32'hf0f01234, gpr_b_data_i = 32'h0ff08001;
  logic [63:0] addend_data_i = 64'h5, multiplier_data_i = 64'h7, multiplicand_data_i = 64'h9;
  logic [63:0] fpu_result_i = 0;
  logic [5:0]  fpu_cause_i = 0;
  logic [4:0]  fp_enables_i = 0, flags_wdata_i = 0;
  wire ready_o, done_o, except_ri_o, except_cpu_o, except_fpe_o, unclaimed_o, gpr_we_o;
  wire link_reservation_flag_o, issue_stall_o, thread_deschedule_o, fpr_we_o, fpu_req_o;
  wire fpu_op_o, fpu_double_o;
  wire [4:0] src_gpr_a_o, src_gpr_b_o, gpr_waddr_o, addend_reg_o, multiplier_reg_o;
  wire [4:0] multiplicand_reg_o, fpr_waddr_o, fp_flags_o;
  wire [5:0] fp_cause_o;
  wire [31:0] gpr_wdata_o;
  wire [63:0] fpr_wdata_o, fpu_a_o, fpu_b_o;
  int errors = 0, cmp_count = 0;
  fnd_decode u_dut (.*);
  always #50 clk_i = ~clk_i;
  // ================================================================
  // Shared tasks
  // ================================================================
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick;  // Step to just after the next rising edge
    @(posedge clk_i);
    #1;
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic send(input logic [31:0] w, input logic keep);  // keep: next word follows
    chk("ready", ready_o, 1);
    instr_i = w;
    instr_valid_i = 1;
    tick;
    if (!keep) instr_valid_i = 0;
  endtask
  task automatic wait_done;  // Bounded wait for retirement
    int n;
    for (n = 0; n < 8 && done_o !== 1'b1; n++) tick;
    if (n == 8) begin
      chk("done_wait", 0, 1);
      summarize;
    end
  endtask
  task automatic fstep(input logic op, input logic [63:0] r, input logic [5:0] c);
    int n;
    for (n = 0; n < 8 && fpu_req_o !== 1'b1; n++) tick;
    if (n == 8) begin
      chk("fpu_wait", 0, 1);
      summarize;
    end
    chk("fpu_op", fpu_op_o, op);
    fpu_result_i = r;
    fpu_cause_i = c;
    fpu_ack_i = 1;
    tick;
    fpu_ack_i = 0;
  endtask
  task pulse_flag(input logic set);  // Linked load or foreign store, one cycle
    if (set) linked_load_i = 1;
    else lock_store_i = 1;
    tick;
    linked_load_i = 0;
    lock_store_i = 0;
  endtask
  // ================================================================
  // Scenarios
  // ================================================================
  task t_logic;
    send(32'h00221827, 1);
    chk("nor_wr", {gpr_we_o, gpr_waddr_o}, 6'h23);
    chk("nor_src", {src_gpr_a_o, src_gpr_b_o}, 10'h022);
    chk("nor_data", gpr_wdata_o, 32'h000f6dca);
    send(32'h00222025, 1);
    chk("or_data", gpr_wdata_o, gpr_a_data_i | gpr_b_data_i);
    send(32'h34258001, 1);
    chk("immor_addr", gpr_waddr_o, 5);
    chk("immor_data", gpr_wdata_o, gpr_a_data_i | 32'h00008001);
    chk("immor_exc", {except_ri_o, except_cpu_o, fpr_we_o}, 0);
    send(32'h00221867, 0);
    chk("nor_shamt", {unclaimed_o, gpr_we_o}, 2'h2);
    $display("logic test done");
  endtask
  task t_zero_word;
    send(32'h00000000, 0);
    chk("zero_word", {done_o, gpr_we_o, fpr_we_o, except_ri_o}, 4'h8);
    pulse_flag(1);
    chk("flag_set", link_reservation_flag_o, 1);
    send(32'h00000140, 0);
    chk("pause_plain", {done_o, issue_stall_o}, 2'h2);
    $display("zero word test done");
  endtask
  task t_pause;
    pause_impl_i = 1;
    send(32'h00000140, 0);
    chk("stall", {issue_stall_o, done_o, ready_o}, 3'h4);
    repeat (3) tick;
    chk("stall_hold", issue_stall_o, 1);
    pulse_flag(0);
    chk("flag_clear", link_reservation_flag_o, 0);
    wait_done;
    chk("stall_end", issue_stall_o, 0);
    pulse_flag(1);
    send(32'h00000140, 0);
    external_event_i = 1;
    tick;
    external_event_i = 0;
    wait_done;
    chk("event_wake", link_reservation_flag_o, 1);
    multithread_i = 1;
    send(32'h00000140, 0);
    external_event_i = 1;
    repeat (2) tick;
    chk("desched", {thread_deschedule_o, done_o}, 2'h2);
    external_event_i = 0;
    pulse_flag(0);
    wait_done;
    multithread_i = 0;
    $display("pause test done");
  endtask
  task t_fp;
    fp_reg_width_mode_i = 0;
    send(32'h4c22193e, 0);
    chk("ps_mode0", except_ri_o, 1);
    send(32'h4c221939, 0);
    chk("fields", {addend_reg_o, multiplier_reg_o, multiplicand_reg_o}, 15'h0443);
    chk("mul_a", fpu_a_o, multiplicand_data_i);
    chk("mul_b", fpu_b_o, multiplier_data_i);
    chk("mul_dbl", fpu_double_o, 1);
    fstep(0, 64'h4000000000000000, 6'h00);
    chk("sub_a", fpu_a_o, 64'h4000000000000000);
    chk("sub_b", fpu_b_o, addend_data_i);
    fstep(1, 64'h3ff0000000000000, 6'h01);
    chk("wr", {fpr_we_o, done_o, fpr_waddr_o}, 7'h64);
    chk("neg", fpr_wdata_o, 64'hbff0000000000000);
    chk("flags", fp_flags_o, 5'h01);
    fp_reg_width_mode_i = 1;
    send(32'h4c22193e, 0);
    chk("ps_single", fpu_double_o, 0);
    fstep(0, 64'h11111111, 6'h00);
    fstep(1, 64'h22222222, 6'h01);
    fstep(0, 64'h33333333, 6'h00);
    fstep(1, 64'h44444444, 6'h02);
    chk("ps_data", fpr_wdata_o, 64'hc4444444a2222222);
    chk("ps_cause", {fp_cause_o, fp_flags_o}, 11'h063);
    fp_enables_i = 5'h10;
    send(32'h4c221939, 0);
    fstep(0, 64'h0, 6'h10);
    chk("trap", {except_fpe_o, fpr_we_o, fp_flags_o}, 7'h43);
    flags_wr_i = 1;
    flags_wdata_i = 5'h04;
    tick;
    flags_wr_i = 0;
    chk("flag_wr", fp_flags_o, 5'h04);
    fp_enables_i = 5'h00;
    cop1_usable_i = 0;
    send(32'h4c221939, 0);
    chk("unusable", except_cpu_o, 1);
    cop1_usable_i = 1;
    fpu64_i = 0;
    send(32'h4c22193e, 0);
    chk("ps_32bit", except_ri_o, 1);
    fpu64_i = 1;
    fpu_present_i = 0;
    send(32'h4c221939, 0);
    chk("no_fpu", {except_ri_o, fpu_req_o}, 2'h2);
    fpu_present_i = 1;
    $display("fp test done");
  endtask
  task t_r6;
    release6_i = 1;
    in_delay_slot_i = 1;
    send(32'h00000140, 0);
    chk("pause_slot", {except_ri_o, done_o}, 2'h2);
    send(32'h4c221939, 0);
    chk("neg_mul_sub_fp_r6", {except_ri_o, fpu_req_o}, 2'h2);
    release6_i = 0;
    in_delay_slot_i = 0;
    $display("release six test done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 reset_n_i = 1;
    t_logic;
    t_zero_word;
    t_pause;
    t_fp;
    t_r6;
    summarize;
  end
endmodule
